// *** design/acs_clock_sel.sv ***
// Automatic sample-clock selector with its AXI4-Lite register slave
// ------------------------------------------------------------------
// Behaviour
// - Each digital input is watched all the time for a valid, locked clock.
// - In auto mode a valid word clock, optical or coaxial input takes over from the crystal as reference.
// - When the reference input dies and none other is valid, the crystal returns.
// - The chosen clock source is preferred and kept while it stays valid.
// - Optical and coaxial receive together, yet only one is the reference.
// - Each of word clock, optical, coaxial and timecode reports none, lock or sync.
// - An input at another rate than the operating rate never shows sync.
// - The current reference, crystal or a named input, is reported.
// - Double rate splits optical samples two ways and leaves four channels.
// - Quad rate splits optical samples four ways and leaves two channels.
// ------------------------------------------------------------------
//
// Chosen here: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "acs_map.svh"

module acs_clock_sel
	import acs_pkg::*;
(
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// AXI4-Lite write address
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	// AXI4-Lite write data
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// AXI4-Lite read address
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Input clock pins
	input  wire logic        word_clk_in,
	input  wire logic        opt_clk_in,
	input  wire logic        coax_clk_in,
	input  wire logic        tc_clk_in,
	// Clock control outputs
	output logic [1:0]       ref_sel,
	output logic             master_mode,
	output logic             double_rate_sample_split,
	output logic             quad_rate_sample_split,
	output logic [3:0]       opt_chan_count,
	// Interrupt
	output logic             irq
);
	acs_ref_t    src_q;
	acs_ref_t    ref_q;
	acs_ref_t    ref_nx;
	acs_speed_t  spd_q;
	logic [10:0] exp_per_q;
	logic [5:0]  mask_q;
	logic [5:0]  irq_sts_q;
	logic [5:0]  irq_set;
	logic [5:0]  irq_clr;
	logic [5:0]  sts_d;
	logic [3:0]  pin_w;
	logic [3:0]  lk_w;
	logic [3:0]  sy_w;
	logic [3:0]  lk_prev_q;
	logic [7:0]  in_sts_q;
	logic [7:0]  aw_addr_q;
	logic        aw_got_q;
	logic [31:0] w_data_q;
	logic [3:0]  w_strb_q;
	logic        w_got_q;
	logic        aw_hs;
	logic        w_hs;
	logic        wr_go;
	logic        ar_hs;
	logic [31:0] ctrl_w;
	logic [31:0] sts_w;
	logic [31:0] rd_w;
	logic [31:0] ctrl_nx;
	logic [31:0] per_nx;
	logic [31:0] mask_nx;

	// ---------------------------------------------------------
	// Helper functions
	// ---------------------------------------------------------

	// Lock of the input behind a reference choice
	function automatic logic ref_ok(acs_ref_t r, logic [3:0] lk);
		ref_ok = (r != REF_INT) && lk[2'(r) - 2'h1];
	endfunction

	// Next reference: crystal, preferred, current, then fixed order
	function automatic acs_ref_t pick(acs_ref_t src, acs_ref_t cur, logic [3:0] lk);
		if (src == REF_INT)
			pick = REF_INT;
		else if (ref_ok(src, lk))
			pick = src;
		else if (ref_ok(cur, lk))
			pick = cur;
		else if (lk[0])
			pick = REF_WCK;
		else if (lk[1])
			pick = REF_OPT;
		else if (lk[2])
			pick = REF_COAX;
		else
			pick = REF_INT;
	endfunction

	// Report code of one input
	function automatic acs_lock_t lk_code(logic lk, logic sy);
		if (sy)
			lk_code = LK_SYNC;
		else if (lk)
			lk_code = LK_LOCK;
		else
			lk_code = LK_NONE;
	endfunction

	// Word address match
	function automatic logic hit(logic [7:0] a, logic [7:0] ofs);
		hit = (a[7:2] == ofs[7:2]);
	endfunction

	// Any register at this address
	function automatic logic mapped(logic [7:0] a);
		mapped = hit(a, `ACS_OFS_CTRL) || hit(a, `ACS_OFS_PER) || hit(a, `ACS_OFS_STS)
			|| hit(a, `ACS_OFS_IRQ) || hit(a, `ACS_OFS_MASK);
	endfunction

	// Byte-lane merge of a write
	function automatic logic [31:0] merge(logic [31:0] old, logic [31:0] nw, logic [3:0] st);
		for (int b = 0; b < 4; b++)
			merge[8*b +: 8] = st[b] ? nw[8*b +: 8] : old[8*b +: 8];
	endfunction

	// ---------------------------------------------------------
	// Input monitors
	// ---------------------------------------------------------
	assign pin_w = {tc_clk_in, coax_clk_in, opt_clk_in, word_clk_in};

	// One monitor per input, all watching at once
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_mon
			acs_rate_mon u_mon (
				.aclk    (aclk),
				.aresetn (aresetn),
				.link_in (pin_w[gi]),
				.exp_per (exp_per_q),
				.locked  (lk_w[gi]),
				.synced  (sy_w[gi])
			);
		end
	endgenerate

	// Per-input report codes
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			in_sts_q <= 8'h00;
		end else begin
			for (int i = 0; i < 4; i++)
				in_sts_q[2*i +: 2] <= lk_code(lk_w[i], sy_w[i]);
		end
	end

	// ---------------------------------------------------------
	// Reference selection
	// ---------------------------------------------------------

	// Timecode never clocks the device, so it is no candidate
	assign ref_nx = pick(src_q, ref_q, lk_w);

	// Single reference register; master whenever the crystal runs
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ref_q       <= REF_INT;
			master_mode <= 1'b1;
		end else begin
			ref_q       <= ref_nx;
			master_mode <= (ref_nx == REF_INT);
		end
	end

	assign ref_sel = ref_q;

	// Optical sample split follows the operating speed range
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			double_rate_sample_split <= 1'b0;
			quad_rate_sample_split   <= 1'b0;
			opt_chan_count           <= `ACS_CH_SINGLE;
		end else begin
			unique case (spd_q)
				SPD_DOUBLE: begin
					double_rate_sample_split <= 1'b1;
					quad_rate_sample_split   <= 1'b0;
					opt_chan_count           <= `ACS_CH_DOUBLE;
				end
				SPD_QUAD: begin
					double_rate_sample_split <= 1'b0;
					quad_rate_sample_split   <= 1'b1;
					opt_chan_count           <= `ACS_CH_QUAD;
				end
				default: begin
					double_rate_sample_split <= 1'b0;
					quad_rate_sample_split   <= 1'b0;
					opt_chan_count           <= `ACS_CH_SINGLE;
				end
			endcase
		end
	end

	// ---------------------------------------------------------
	// Interrupt status
	// ---------------------------------------------------------

	// Lock changes, reference changes and fallback to the crystal
	always_comb begin
		irq_set = 6'h00;
		irq_set[`ACS_IRQ_LK_LSB +: 4] = lk_w ^ lk_prev_q;
		irq_set[`ACS_IRQ_REF_BIT] = (ref_nx != ref_q);
		irq_set[`ACS_IRQ_FB_BIT] = (ref_nx == REF_INT) && (ref_q != REF_INT);
	end

	// Read clears, but an event in the same cycle survives
	assign irq_clr = (ar_hs && hit(s_axi_araddr, `ACS_OFS_IRQ)) ? 6'h3F : 6'h00;
	assign sts_d   = (irq_sts_q & ~irq_clr) | irq_set;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_sts_q <= 6'h00;
			lk_prev_q <= 4'h0;
			irq       <= 1'b0;
		end else begin
			irq_sts_q <= sts_d;
			lk_prev_q <= lk_w;
			irq       <= |(sts_d & mask_q);
		end
	end

	// ---------------------------------------------------------
	// AXI4-Lite write path
	// ---------------------------------------------------------
	assign aw_hs = s_axi_awvalid && s_axi_awready;
	assign w_hs  = s_axi_wvalid && s_axi_wready;
	assign wr_go = aw_got_q && w_got_q && !s_axi_bvalid;

	// Address and data held apart so either may arrive first
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_q      <= 1'b0;
			aw_addr_q     <= 8'h00;
			s_axi_awready <= 1'b0;
		end else begin
			if (aw_hs) begin
				aw_got_q  <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
			end else if (wr_go) begin
				aw_got_q  <= 1'b0;
			end
			s_axi_awready <= !(aw_hs || (aw_got_q && !wr_go));
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_got_q      <= 1'b0;
			w_data_q     <= 32'h0000_0000;
			w_strb_q     <= 4'h0;
			s_axi_wready <= 1'b0;
		end else begin
			if (w_hs) begin
				w_got_q  <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end else if (wr_go) begin
				w_got_q  <= 1'b0;
			end
			s_axi_wready <= !(w_hs || (w_got_q && !wr_go));
		end
	end

	// Response one cycle after both halves are in
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `ACS_RESP_OKAY;
		end else if (wr_go) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= mapped(aw_addr_q) ? `ACS_RESP_OKAY : `ACS_RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Control word as seen by software
	always_comb begin
		ctrl_w = 32'h0000_0000;
		ctrl_w[`ACS_SRC_LSB +: 2] = src_q;
		ctrl_w[`ACS_SPD_LSB +: 2] = spd_q;
	end

	assign ctrl_nx = merge(ctrl_w, w_data_q, w_strb_q);
	assign per_nx  = merge({21'h0, exp_per_q}, w_data_q, w_strb_q);
	assign mask_nx = merge({26'h0, mask_q}, w_data_q, w_strb_q);

	// Writable registers; status words ignore writes
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			src_q     <= acs_ref_t'(`ACS_RST_SRC);
			spd_q     <= acs_speed_t'(`ACS_RST_SPD);
			exp_per_q <= `ACS_RST_PER;
			mask_q    <= `ACS_RST_MASK;
		end else if (wr_go) begin
			if (hit(aw_addr_q, `ACS_OFS_CTRL)) begin
				src_q <= acs_ref_t'(ctrl_nx[`ACS_SRC_LSB +: 2]);
				spd_q <= acs_speed_t'(ctrl_nx[`ACS_SPD_LSB +: 2]);
			end
			if (hit(aw_addr_q, `ACS_OFS_PER))
				exp_per_q <= per_nx[10:0];
			if (hit(aw_addr_q, `ACS_OFS_MASK))
				mask_q <= mask_nx[5:0];
		end
	end

	// ---------------------------------------------------------
	// AXI4-Lite read path
	// ---------------------------------------------------------
	assign ar_hs = s_axi_arvalid && s_axi_arready;

	// Status word: reference, split mode and per-input codes
	always_comb begin
		sts_w = 32'h0000_0000;
		sts_w[`ACS_STS_REF_LSB +: 2] = ref_q;
		sts_w[`ACS_STS_MST_BIT] = master_mode;
		sts_w[`ACS_STS_DBL_BIT] = double_rate_sample_split;
		sts_w[`ACS_STS_QUAD_BIT] = quad_rate_sample_split;
		sts_w[`ACS_STS_CH_LSB +: 4] = opt_chan_count;
		sts_w[`ACS_STS_IN_LSB +: 8] = in_sts_q;
	end

	// Read multiplexer
	always_comb begin
		rd_w = 32'h0000_0000;
		if (hit(s_axi_araddr, `ACS_OFS_CTRL))
			rd_w = ctrl_w;
		else if (hit(s_axi_araddr, `ACS_OFS_PER))
			rd_w = {21'h0, exp_per_q};
		else if (hit(s_axi_araddr, `ACS_OFS_STS))
			rd_w = sts_w;
		else if (hit(s_axi_araddr, `ACS_OFS_IRQ))
			rd_w = {26'h0, irq_sts_q};
		else if (hit(s_axi_araddr, `ACS_OFS_MASK))
			rd_w = {26'h0, mask_q};
	end

	// One read at a time; data captured at the address handshake
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= `ACS_RESP_OKAY;
		end else begin
			s_axi_arready <= !(ar_hs || (s_axi_rvalid && !s_axi_rready));
			if (ar_hs) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rd_w;
				s_axi_rresp  <= mapped(s_axi_araddr) ? `ACS_RESP_OKAY : `ACS_RESP_SLVERR;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// ---------------------------------------------------------
	// Checks
	// ---------------------------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_go_slave;
		src_q != REF_INT && ref_q == REF_INT && (|lk_w[2:0])
			|=> ref_q != REF_INT && !master_mode;
	endproperty
	a_go_slave: assert property (p_go_slave)
		else $error("valid input not taken as reference");

	property p_fallback;
		src_q != REF_INT && ref_q != REF_INT && lk_w[2:0] == 3'h0
			|=> ref_q == REF_INT && master_mode;
	endproperty
	a_fallback: assert property (p_fallback)
		else $error("no return to the crystal");

	sequence s_pref_held;
		src_q != REF_INT && ref_ok(src_q, lk_w);
	endsequence
	property p_pref_keep;
		s_pref_held |=> ref_q == $past(src_q);
	endproperty
	a_pref_keep: assert property (p_pref_keep)
		else $error("preferred input dropped while valid");

	property p_one_ref;
		lk_w[1] && lk_w[2] && src_q == REF_OPT |=> ref_sel == 2'(REF_OPT);
	endproperty
	a_one_ref: assert property (p_one_ref)
		else $error("coaxial chosen over a valid preferred optical");

	sequence s_lock_only;
		lk_w[1] && !sy_w[1];
	endsequence
	property p_lock_report;
		s_lock_only |=> in_sts_q[3:2] == 2'(LK_LOCK);
	endproperty
	a_lock_report: assert property (p_lock_report)
		else $error("optical status not shown as lock");

	sequence s_rd_sts;
		ar_hs && hit(s_axi_araddr, `ACS_OFS_STS);
	endsequence
	property p_ref_report;
		s_rd_sts |=> s_axi_rvalid && s_axi_rdata[1:0] == $past(ref_q);
	endproperty
	a_ref_report: assert property (p_ref_report)
		else $error("status read shows wrong reference");

	property p_double;
		spd_q == SPD_DOUBLE |=> double_rate_sample_split
			&& !quad_rate_sample_split && opt_chan_count == `ACS_CH_DOUBLE;
	endproperty
	a_double: assert property (p_double)
		else $error("double rate split wrong");

	property p_quad;
		(spd_q == SPD_QUAD) [*2] |-> quad_rate_sample_split
			&& !double_rate_sample_split && opt_chan_count == `ACS_CH_QUAD;
	endproperty
	a_quad: assert property (p_quad)
		else $error("quad rate split wrong");

	property p_priority;
		src_q == REF_COAX && !lk_w[2] && !ref_ok(ref_q, lk_w) && lk_w[0]
			|=> ref_q == REF_WCK;
	endproperty
	a_priority: assert property (p_priority)
		else $error("fixed order not kept");
endmodule

// *** design/acs_clock_sel_end.sv ***
// (unused)

// *** design/acs_map.svh ***
// Register offsets, field positions, reset values and timing counts
`ifndef ACS_MAP_SVH
`define ACS_MAP_SVH

// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define ACS_OFS_CTRL     8'h00
`define ACS_OFS_PER      8'h04
`define ACS_OFS_STS      8'h08
`define ACS_OFS_IRQ      8'h0C
`define ACS_OFS_MASK     8'h10

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define ACS_SRC_LSB      0
`define ACS_SPD_LSB      4
`define ACS_STS_REF_LSB  0
`define ACS_STS_MST_BIT  2
`define ACS_STS_DBL_BIT  3
`define ACS_STS_QUAD_BIT 4
`define ACS_STS_CH_LSB   8
`define ACS_STS_IN_LSB   16
`define ACS_IRQ_LK_LSB   0
`define ACS_IRQ_REF_BIT  4
`define ACS_IRQ_FB_BIT   5

// ---------------------------------------------------------------
// Reset values and fixed codes
// ---------------------------------------------------------------
`define ACS_RST_SRC      2'h2
`define ACS_RST_SPD      2'h0
`define ACS_RST_PER      11'h008
`define ACS_RST_MASK     6'h00
`define ACS_CH_SINGLE    4'h8
`define ACS_CH_DOUBLE    4'h4
`define ACS_CH_QUAD      4'h2
`define ACS_RESP_OKAY    2'h0
`define ACS_RESP_SLVERR  2'h2

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define ACS_CLK_NS       100
`define ACS_LOSS_NS      110000
`define ACS_LOSS_CYC     11'(`ACS_LOSS_NS / `ACS_CLK_NS)
`define ACS_PER_MIN      11'h004
`define ACS_PER_MAX      11'h3E8
`define ACS_JIT          11'h001
`define ACS_SYNC_TOL     11'h001

`endif

// *** design/acs_pkg.sv ***
// Types shared by the clock selector files
package acs_pkg;
	typedef enum logic [1:0] {REF_INT, REF_WCK, REF_OPT, REF_COAX} acs_ref_t;
	typedef enum logic [1:0] {SPD_SINGLE, SPD_DOUBLE, SPD_QUAD} acs_speed_t;
	typedef enum logic [1:0] {LK_NONE, LK_LOCK, LK_SYNC} acs_lock_t;
endpackage

// *** design/acs_rate_mon.sv ***
// Lock and rate monitor for one input clock pin
`timescale 1ns/1ps
`include "acs_map.svh"

module acs_rate_mon (
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// Raw pin and expected period
	input  wire logic        link_in,
	input  wire logic [10:0] exp_per,
	// Results
	output logic             locked,
	output logic             synced
);
	logic        s0_q;
	logic        s1_q;
	logic        prev_q;
	logic [10:0] cnt_q;
	logic [10:0] per_q;
	logic        lk_q;
	logic        sy_q;
	logic        rise;
	logic [10:0] per_new;

	// Distance test between two periods
	function automatic logic near(logic [10:0] a, logic [10:0] b, logic [10:0] tol);
		near = ((a > b) ? (a - b) : (b - a)) <= tol;
	endfunction

	// --------------------------------------------------------
	// Pin synchroniser; edges are seen on the second stage only
	// --------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s0_q   <= 1'b0;
			s1_q   <= 1'b0;
			prev_q <= 1'b0;
		end else begin
			s0_q   <= link_in;
			s1_q   <= s0_q;
			prev_q <= s1_q;
		end
	end

	assign rise    = s1_q && !prev_q;
	assign per_new = cnt_q + 11'h001;

	// Period counter, saturates so a dead pin reads as too slow
	always_ff @(posedge aclk) begin
		if (!aresetn)
			cnt_q <= 11'h000;
		else if (rise)
			cnt_q <= 11'h000;
		else if (cnt_q != `ACS_LOSS_CYC)
			cnt_q <= cnt_q + 11'h001;
	end

	// Lock needs two matching periods inside the legal window
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			per_q <= 11'h000;
			lk_q  <= 1'b0;
		end else if (rise) begin
			per_q <= per_new;
			lk_q  <= (per_new >= `ACS_PER_MIN) && (per_new <= `ACS_PER_MAX)
				&& near(per_new, per_q, `ACS_JIT);
		end else if (cnt_q == `ACS_LOSS_CYC) begin
			lk_q  <= 1'b0;
		end
	end

	// Sync only when the rate matches the operating rate
	always_ff @(posedge aclk) begin
		if (!aresetn)
			sy_q <= 1'b0;
		else
			sy_q <= lk_q && near(per_q, exp_per, `ACS_SYNC_TOL);
	end

	assign locked = lk_q;
	assign synced = sy_q;

	// --------------------------------------------------------
	// Checks
	// --------------------------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_loss;
		cnt_q == `ACS_LOSS_CYC |=> !lk_q;
	endproperty
	a_loss: assert property (p_loss)
		else $error("lock kept on a silent input");

	property p_too_fast;
		rise && (per_new < `ACS_PER_MIN) |=> !lk_q;
	endproperty
	a_too_fast: assert property (p_too_fast)
		else $error("lock taken on a too short period");

	property p_sync_rate;
		sy_q |-> $past(lk_q) && $past(near(per_q, exp_per, `ACS_SYNC_TOL));
	endproperty
	a_sync_rate: assert property (p_sync_rate)
		else $error("sync shown at a foreign rate");
endmodule

// *** verification/acs_clock_sel_bench.sv ***
// Self-checking bench for the automatic clock selector
`timescale 1ns/1ps
`include "acs_map.svh"

module acs_clock_sel_bench
	import acs_pkg::*;
;
	typedef struct packed {
		logic [3:0] en;
		logic [1:0] src;
		logic [1:0] spd;
		logic [1:0] rf;
		logic       mst;
		logic [3:0] ch;
	} acs_row_t;

	logic        aclk, aresetn;
	logic [7:0]  awaddr, araddr;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready;
	logic [31:0] wdata, rdata, rdv;
	logic [3:0]  wstrb, en, ch;
	logic [1:0]  bresp, rresp, ref_sel, rs;
	logic        wck, opt, coax, tc, mst, dbl, quad, irq;
	int          n_fail, compares;

	// Ordinary cases: enables, source, speed, then expected outputs
	acs_row_t rows [6] = '{
		'{4'h0, 2'h2, 2'h0, REF_INT,  1'b1, `ACS_CH_SINGLE},
		'{4'h6, 2'h2, 2'h1, REF_OPT,  1'b0, `ACS_CH_DOUBLE},
		'{4'h6, 2'h3, 2'h2, REF_COAX, 1'b0, `ACS_CH_QUAD},
		'{4'h3, 2'h3, 2'h3, REF_WCK,  1'b0, `ACS_CH_SINGLE},
		'{4'hF, 2'h0, 2'h0, REF_INT,  1'b1, `ACS_CH_SINGLE},
		'{4'h8, 2'h1, 2'h0, REF_INT,  1'b1, `ACS_CH_SINGLE}
	};

	acs_clock_sel uut (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.word_clk_in(wck), .opt_clk_in(opt), .coax_clk_in(coax), .tc_clk_in(tc),
		.ref_sel(ref_sel), .master_mode(mst), .double_rate_sample_split(dbl),
		.quad_rate_sample_split(quad), .opt_chan_count(ch), .irq(irq)
	);

	acs_src_model src (
		.en(en), .word_clk_in(wck), .opt_clk_in(opt), .coax_clk_in(coax),
		.tc_clk_in(tc)
	);

	// 10 MHz clock
	initial begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end

	// ---------------------------------------------------------------
	// Checking and bus tasks
	// ---------------------------------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Write: address and data offered together, each released when taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (n < 100) begin
			@(posedge aclk);
			n++;
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid && bready) begin
				rs = bresp;
				bready <= 1'b0;
				n = 1000;
			end
		end
		if (n < 1000) chk(32'h0, 32'h1);
	endtask

	task automatic rd(input logic [7:0] a);
		int n;
		n = 0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (n < 100) begin
			@(posedge aclk);
			n++;
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid && rready) begin
				rs = rresp;
				rdv = rdata;
				rready <= 1'b0;
				n = 1000;
			end
		end
		if (n < 1000) chk(32'h0, 32'h1);
	endtask

	// Status word: input codes 2 when running at the operating rate
	function automatic logic [31:0] sts_exp(acs_row_t r, logic [1:0] code);
		logic [31:0] s;
		s = {20'h0, r.ch, 3'h0, r.ch == `ACS_CH_QUAD, r.ch == `ACS_CH_DOUBLE, r.mst, r.rf};
		for (int i = 0; i < 4; i++) s[16 + 2 * i +: 2] = r.en[i] ? code : 2'h0;
		return s;
	endfunction

	task automatic print_verdict();
		$display("compares %0d mismatches %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// Watchdog, well beyond the roughly 1.4 ms of tests
	initial begin
		#4000000;
		n_fail++;
		$display("watchdog expired");
		print_verdict();
	end

	// ---------------------------------------------------------------
	// Stimulus and checks
	// ---------------------------------------------------------------
	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
		{awaddr, araddr, wdata, en} = '0;
		wstrb = 4'hF;
		repeat (5) @(posedge aclk);
		chk({ref_sel, mst, ch, irq}, {REF_INT, 1'b1, `ACS_CH_SINGLE, 1'b0});
		aresetn <= 1'b1;
		rd(`ACS_OFS_CTRL);
		chk(rdv, {26'h0, `ACS_RST_SPD, 2'h0, `ACS_RST_SRC});
		rd(`ACS_OFS_PER);
		chk(rdv, {21'h0, `ACS_RST_PER});
		$display("reset test done");
		// Table of selection cases
		foreach (rows[i]) begin
			wr(`ACS_OFS_CTRL, {26'h0, rows[i].spd, 2'h0, rows[i].src});
			en <= rows[i].en;
			repeat (1500) @(posedge aclk);
			chk({ref_sel, mst, dbl, quad, ch}, {rows[i].rf, rows[i].mst,
				rows[i].ch == `ACS_CH_DOUBLE, rows[i].ch == `ACS_CH_QUAD, rows[i].ch});
			rd(`ACS_OFS_STS);
			chk(rdv, sts_exp(rows[i], 2'h2));
			$display("row %0d done", i);
		end
		// Rate mismatch: timecode stays locked but loses sync
		wr(`ACS_OFS_PER, 32'h0000_000A);
		repeat (100) @(posedge aclk);
		rd(`ACS_OFS_STS);
		chk(rdv, sts_exp(rows[5], 2'h1));
		wr(`ACS_OFS_PER, 32'h0000_0008);
		$display("rate test done");
		// Mid-run reset with optical as reference
		wr(`ACS_OFS_CTRL, 32'h0000_0002);
		en <= 4'h2;
		repeat (1500) @(posedge aclk);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		chk({ref_sel, mst, ch, irq}, {REF_INT, 1'b1, `ACS_CH_SINGLE, 1'b0});
		aresetn <= 1'b1;
		repeat (1500) @(posedge aclk);
		chk(ref_sel, REF_OPT);
		$display("second reset done");
		// Interrupt: masked, unmasked, cleared by reading
		rd(`ACS_OFS_IRQ);
		en <= 4'h0;
		repeat (1500) @(posedge aclk);
		chk({ref_sel, mst, irq}, {REF_INT, 2'b10});
		wr(`ACS_OFS_MASK, 32'h0000_0020);
		repeat (2) @(posedge aclk);
		chk(irq, 1'b1);
		rd(`ACS_OFS_IRQ);
		chk(rdv, 32'h0000_0032);
		repeat (2) @(posedge aclk);
		chk(irq, 1'b0);
		rd(`ACS_OFS_IRQ);
		chk(rdv, 32'h0);
		$display("interrupt test done");
		// Unmapped and read-only places
		// Response and data checked apart so neither is cut off
		rd(8'h14);
		chk(rs, `ACS_RESP_SLVERR);
		chk(rdv, 32'h0);
		wr(8'h14, 32'hFFFF_FFFF);
		chk(rs, `ACS_RESP_SLVERR);
		wr(`ACS_OFS_STS, 32'hFFFF_FFFF);
		chk(rs, `ACS_RESP_OKAY);
		rd(`ACS_OFS_STS);
		chk(rdv, sts_exp(rows[0], 2'h0));
		rd(`ACS_OFS_CTRL);
		chk(rdv, 32'h0000_0002);
		$display("error test done");
		print_verdict();
	end
endmodule

// *** verification/acs_src_model.sv ***
// Model of the external digital sources that drive the four clock pins
`timescale 1ns/1ps

module acs_src_model #(
	parameter int HALF_NS = 400
) (
	// Source enables: word clock, optical, coaxial, timecode
	input  wire logic [3:0] en,
	// Clock pins
	output logic            word_clk_in,
	output logic            opt_clk_in,
	output logic            coax_clk_in,
	output logic            tc_clk_in
);
	logic [3:0] pin;

	// Idle sources stand low; offsets of 13 to 34 ns keep edges off the aclk grid
	for (genvar i = 0; i < 4; i++) begin : g_src
		initial begin
			pin[i] = 1'b0;
			#(13 + 7 * i);
			forever begin
				pin[i] = en[i];
				#(HALF_NS);
				pin[i] = 1'b0;
				#(HALF_NS);
			end
		end
	end

	// Pin order matches the enables
	assign {tc_clk_in, coax_clk_in, opt_clk_in, word_clk_in} = pin;
endmodule
